// file: rof_pkg.sv
// Shared constants for the ring OAM frame handler and its ring peer.
// Overview of operation
// - Group code 0001 marks fault management.
// - Functions: 1000 echo request, 1001 response, 0001 flush.
// - Reply path select chooses the echo reply ringlet.
// - Path select: 0 default, 1 ringlet0, 2 ringlet1.
// - Failover bit steers the reply under ring failure.
// - Failover bit: 0 protected, 1 unprotected.
// - Echo payload bytes are copied back unaltered.
// - Payload is opaque and any length, even zero.
// - Flush byte after header is reserved, ignored.
// - Detect control frame of OAM type for us.
// - Classify by group and function code table.
// - Drop frames with unsupported group or function.
// - Report every such drop as an event.
// - Detection checks are order independent, parallel.
// - Reply: response code, own source, request source destination.
// - OAM frames are padded to 24 bytes minimum; target echo replies keep a short request's length.
// - Requester fills response control with reply wishes.
package rof_pkg;

  localparam logic [7:0] OAM_CTRL_TYPE    = 8'h03;
  localparam logic [3:0] GRP_FAULT        = 4'h1;
  localparam logic [3:0] FN_ECHO_REQ      = 4'h8;
  localparam logic [3:0] FN_ECHO_RSP      = 4'h9;
  localparam logic [3:0] FN_FLUSH         = 4'h1;
  localparam logic [1:0] RPS_DEFAULT      = 2'h0;
  localparam logic [1:0] RPS_RING0        = 2'h1;
  localparam logic [1:0] RPS_RING1        = 2'h2;
  localparam logic       POLICY_PROTECTED = 1'h0;
  localparam logic [7:0] PAD_BYTE         = 8'h00;
  localparam logic [7:0] RESERVED_BYTE    = 8'h00;

  localparam int OFS_TYPE      = 0;
  localparam int OFS_DA        = 1;
  localparam int OFS_SA        = 2;
  localparam int OFS_CODES     = 3;
  localparam int OFS_RSPCTL    = 4;
  localparam int HDR_LEN       = 5;
  localparam int RPS_LSB       = 0;
  localparam int FAILOVER_POS  = 2;
  localparam int MIN_FRAME_LEN = 24;

endpackage : rof_pkg

// file: rof_ring_if.sv
// Byte stream link between the OAM target and a peer ring station.
`timescale 1ns/1ps
interface rof_ring_if;
  logic       reqValid;
  logic       reqSop;
  logic       reqEop;
  logic [7:0] reqData;
  logic       rspValid;
  logic       rspSop;
  logic       rspEop;
  logic [7:0] rspData;
  logic       rspRinglet;

  modport target (
    input  reqValid, reqSop, reqEop, reqData,
    output rspValid, rspSop, rspEop, rspData, rspRinglet
  );

  modport peer (
    output reqValid, reqSop, reqEop, reqData,
    input  rspValid, rspSop, rspEop, rspData, rspRinglet
  );
endinterface : rof_ring_if

// file: rof_target.sv
// Device end: detects OAM frames, reports them and answers echo requests.
`timescale 1ns/1ps
module rof_target
  import rof_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] myAddr,
  input  wire logic       defaultRinglet,
  input  wire logic [1:0] ringletFailed,
  output logic            echoReqSeen,
  output logic            echoRspSeen,
  output logic            flushSeen,
  output logic            dropEvent,
  output logic            runtSeen,
  rof_ring_if.target      ring
);

  // The frame is held back by exactly the header length, so the header
  // is fully decoded when its first byte leaves the delay line.
  localparam int DELAY = HDR_LEN;

  if (DELAY < OFS_RSPCTL + 1) begin : g_chk
    $error("Delay line shorter than the OAM control header.");
  end

  logic [7:0]       hdr_q [HDR_LEN];
  logic             hdrDone_q;
  logic             hdrFresh_q;
  logic [4:0]       inCnt_q;
  logic [4:0]       inCnt_d;
  logic [7:0]       dlData_q [DELAY];
  logic [DELAY-1:0] dlValid_q;
  logic [DELAY-1:0] dlSop_q;
  logic [DELAY-1:0] dlEop_q;
  logic             fwd_q;
  logic             fwd_d;
  logic [2:0]       outPos_q;
  logic [2:0]       outPos_d;
  logic [7:0]       replyDa_q;
  logic             rspValid_q;
  logic             rspSop_q;
  logic             rspEop_q;
  logic [7:0]       rspData_q;
  logic             rspRinglet_q;
  logic             echoReqSeen_q;
  logic             echoRspSeen_q;
  logic             flushSeen_q;
  logic             dropEvent_q;
  logic             runtSeen_q;

  // Input byte position; it saturates once the minimum length is reached.
  wire [4:0] inIdx      = ring.reqSop ? 5'h00 : inCnt_q;
  wire       inStoreHdr = ring.reqValid && (inIdx < 5'(HDR_LEN));
  wire       inLastHdr  = ring.reqValid && (inIdx == 5'(HDR_LEN - 1));
  wire       inRunt     = ring.reqValid && ring.reqEop &&
                          (inIdx < 5'(MIN_FRAME_LEN - 1));

  // All header checks run side by side, none gates another.
  wire       isOamCtrl = hdr_q[OFS_TYPE] == OAM_CTRL_TYPE;
  wire       forMe     = hdr_q[OFS_DA] == myAddr;
  wire [3:0] grpCode   = hdr_q[OFS_CODES][7:4];
  wire [3:0] fnCode    = hdr_q[OFS_CODES][3:0];
  wire       grpFault  = grpCode == GRP_FAULT;
  wire       kEchoReq  = grpFault && (fnCode == FN_ECHO_REQ);
  wire       kEchoRsp  = grpFault && (fnCode == FN_ECHO_RSP);
  wire       kFlush    = grpFault && (fnCode == FN_FLUSH);
  wire       supported = kEchoReq || kEchoRsp || kFlush;
  wire       detected  = hdrDone_q && isOamCtrl && forMe;

  // Response control subfields; flush frames never look at this byte.
  wire [1:0] pathCode  = hdr_q[OFS_RSPCTL][RPS_LSB +: 2];
  wire       policyBit = hdr_q[OFS_RSPCTL][FAILOVER_POS];

  // Codes 0 and 3 both fall back to the default ringlet.
  wire       pathSel   = (pathCode == RPS_RING0) ? 1'b0 :
                         (pathCode == RPS_RING1) ? 1'b1 :
                         defaultRinglet;

  // A protected reply moves to the other ringlet if its own has failed;
  // an unprotected one stays put and may be lost with the ringlet.
  wire       failSwap  = ringletFailed[pathSel] &&
                         (policyBit == POLICY_PROTECTED);
  wire       replyRing = pathSel ^ failSwap;

  wire       tailValid = dlValid_q[DELAY-1];
  wire       tailSop   = dlSop_q[DELAY-1];
  wire       tailEop   = dlEop_q[DELAY-1];
  wire [7:0] tailData  = dlData_q[DELAY-1];

  // Frames shorter than the header never set hdrDone_q and are not answered.
  wire       startReply = tailValid && tailSop && detected && kEchoReq;
  wire       sendByte   = tailValid && (tailSop ? startReply : fwd_q);
  wire [2:0] outPos     = tailSop ? 3'h0 : outPos_q;

  // Destination, source and code bytes are rewritten; every other byte passes through untouched.
  wire [7:0] outByte =
    (outPos == 3'(OFS_DA))    ? replyDa_q :
    (outPos == 3'(OFS_SA))    ? myAddr :
    (outPos == 3'(OFS_CODES)) ? {GRP_FAULT, FN_ECHO_RSP} :
    tailData;

  always_comb begin
    inCnt_d = inCnt_q;
    if (ring.reqValid) begin
      inCnt_d = (inIdx == 5'(MIN_FRAME_LEN)) ? inIdx : inIdx + 5'h01;
    end
  end

  always_comb begin
    fwd_d = fwd_q;
    if (tailValid && tailSop) begin
      fwd_d = startReply && !tailEop;
    end else if (tailValid && tailEop) begin
      fwd_d = 1'b0;
    end
  end

  always_comb begin
    outPos_d = outPos_q;
    if (tailValid) begin
      outPos_d = (outPos == 3'(HDR_LEN)) ? outPos : outPos + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      inCnt_q    <= 5'h00;
      hdrDone_q  <= 1'b0;
      hdrFresh_q <= 1'b0;
    end else begin
      inCnt_q    <= inCnt_d;
      hdrFresh_q <= inLastHdr;
      if (inLastHdr) begin
        hdrDone_q <= 1'b1;
      end else if (ring.reqValid && ring.reqSop) begin
        hdrDone_q <= 1'b0;
      end
    end
  end

  // Header bytes are data only; they need no reset.
  always_ff @(posedge clk) begin
    if (inStoreHdr) begin
      hdr_q[inIdx[2:0]] <= ring.reqData;
    end
  end

  always_ff @(posedge clk) begin
    dlData_q[0] <= ring.reqData;
    for (int i = 1; i < DELAY; i++) begin
      dlData_q[i] <= dlData_q[i-1];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dlValid_q <= '0;
      dlSop_q   <= '0;
      dlEop_q   <= '0;
    end else begin
      dlValid_q <= {dlValid_q[DELAY-2:0], ring.reqValid};
      dlSop_q   <= {dlSop_q[DELAY-2:0], ring.reqSop};
      dlEop_q   <= {dlEop_q[DELAY-2:0], ring.reqEop};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fwd_q        <= 1'b0;
      outPos_q     <= 3'h0;
      replyDa_q    <= 8'h00;
      rspRinglet_q <= 1'b0;
    end else begin
      fwd_q    <= fwd_d;
      outPos_q <= outPos_d;
      if (startReply) begin
        replyDa_q    <= hdr_q[OFS_SA];
        rspRinglet_q <= replyRing;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rspValid_q <= 1'b0;
      rspSop_q   <= 1'b0;
      rspEop_q   <= 1'b0;
      rspData_q  <= 8'h00;
    end else begin
      rspValid_q <= sendByte;
      rspSop_q   <= sendByte && tailSop;
      rspEop_q   <= sendByte && tailEop;
      if (sendByte) begin
        rspData_q <= outByte;
      end
    end
  end

  // Header events fire once per frame, in the cycle after the header completes; runtSeen fires the cycle after a short frame's last byte.
  always_ff @(posedge clk) begin
    if (reset) begin
      echoReqSeen_q <= 1'b0;
      echoRspSeen_q <= 1'b0;
      flushSeen_q   <= 1'b0;
      dropEvent_q   <= 1'b0;
      runtSeen_q    <= 1'b0;
    end else begin
      echoReqSeen_q <= hdrFresh_q && detected && kEchoReq;
      echoRspSeen_q <= hdrFresh_q && detected && kEchoRsp;
      flushSeen_q   <= hdrFresh_q && detected && kFlush;
      dropEvent_q   <= hdrFresh_q && detected && !supported;
      runtSeen_q    <= inRunt;
    end
  end

  assign ring.rspValid   = rspValid_q;
  assign ring.rspSop     = rspSop_q;
  assign ring.rspEop     = rspEop_q;
  assign ring.rspData    = rspData_q;
  assign ring.rspRinglet = rspRinglet_q;
  assign echoReqSeen     = echoReqSeen_q;
  assign echoRspSeen     = echoRspSeen_q;
  assign flushSeen       = flushSeen_q;
  assign dropEvent       = dropEvent_q;
  assign runtSeen        = runtSeen_q;

endmodule : rof_target

// file: rof_peer.sv
// Peer end: sends echo requests and flush frames and checks echo replies.
`timescale 1ns/1ps
module rof_peer
  import rof_pkg::*;
#(
  parameter int LEN_W = 8
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [7:0]       myAddr,
  input  wire logic             startEcho,
  input  wire logic             startFlush,
  input  wire logic [7:0]       dstAddr,
  input  wire logic [1:0]       replyPath,
  input  wire logic             failoverBit,
  input  wire logic [LEN_W-1:0] payloadLen,
  input  wire logic [7:0]       payloadSeed,
  output logic                  busy,
  output logic                  echoRspGot,
  output logic                  echoRspOk,
  output logic                  echoRspRing,
  rof_ring_if.peer              ring
);

  localparam int POS_W = LEN_W + 1;

  // Payload bytes take the low eight bits of the byte offset, so the
  // offset counter must be at least eight bits wide.
  if (LEN_W < 7 || LEN_W > 16) begin : g_chk
    $error("Payload length width must lie between 7 and 16.");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } rof_peer_state_e;

  rof_peer_state_e  state_q;
  logic [POS_W-1:0] txPos_q;
  logic             isEcho_q;
  logic [7:0]       dst_q;
  logic [7:0]       ctl_q;
  logic [LEN_W-1:0] len_q;
  logic [7:0]       seed_q;
  logic             reqValid_q;
  logic             reqSop_q;
  logic             reqEop_q;
  logic [7:0]       reqData_q;
  logic [POS_W-1:0] rxPos_q;
  logic             rxGood_q;
  logic             rxMatch_q;
  logic             echoRspGot_q;
  logic             echoRspOk_q;
  logic             echoRspRing_q;

  wire              start    = (state_q == ST_IDLE) && (startEcho || startFlush);
  wire [POS_W-1:0]  dataEnd  = POS_W'(HDR_LEN) + POS_W'(len_q);
  wire [POS_W-1:0]  frameEnd = (dataEnd < POS_W'(MIN_FRAME_LEN)) ?
                               POS_W'(MIN_FRAME_LEN) : dataEnd;
  wire [POS_W-1:0]  txOfs    = txPos_q - POS_W'(HDR_LEN);
  wire              txLast   = txPos_q == frameEnd - POS_W'(1);
  wire [3:0]        txFn     = isEcho_q ? FN_ECHO_REQ : FN_FLUSH;

  // The reserved flush byte is sent as a fixed filler.
  wire [7:0] txByte =
    (txPos_q == POS_W'(OFS_TYPE))   ? OAM_CTRL_TYPE :
    (txPos_q == POS_W'(OFS_DA))     ? dst_q :
    (txPos_q == POS_W'(OFS_SA))     ? myAddr :
    (txPos_q == POS_W'(OFS_CODES))  ? {GRP_FAULT, txFn} :
    (txPos_q == POS_W'(OFS_RSPCTL)) ? (isEcho_q ? ctl_q : RESERVED_BYTE) :
    (txPos_q < dataEnd)             ? seed_q + txOfs[7:0] : PAD_BYTE;

  // Reply check: type, destination and code bytes and the payload are checked; source and control bytes are not.
  wire [POS_W-1:0] rxPos  = ring.rspSop ? '0 : rxPos_q;
  wire [POS_W-1:0] rxOfs  = rxPos - POS_W'(HDR_LEN);
  wire             rxHdr  =
    (rxPos == POS_W'(OFS_TYPE))  ? ring.rspData == OAM_CTRL_TYPE :
    (rxPos == POS_W'(OFS_DA))    ? ring.rspData == myAddr :
    (rxPos == POS_W'(OFS_CODES)) ? ring.rspData == {GRP_FAULT, FN_ECHO_RSP} :
    1'b1;
  wire             rxData = (rxPos < POS_W'(HDR_LEN)) ||
                            (rxPos >= dataEnd) ||
                            (ring.rspData == seed_q + rxOfs[7:0]);
  wire             rxGood = (ring.rspSop || rxGood_q) && rxHdr;
  wire             rxMat  = (ring.rspSop || rxMatch_q) && rxData;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q  <= ST_IDLE;
      txPos_q  <= '0;
      isEcho_q <= 1'b0;
      dst_q    <= 8'h00;
      ctl_q    <= 8'h00;
      len_q    <= '0;
      seed_q   <= 8'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          txPos_q <= '0;
          if (start) begin
            state_q  <= ST_SEND;
            isEcho_q <= startEcho;
            dst_q    <= dstAddr;
            len_q    <= payloadLen;
            seed_q   <= payloadSeed;
            ctl_q    <= 8'h00;
            ctl_q[RPS_LSB +: 2]  <= replyPath;
            ctl_q[FAILOVER_POS]  <= failoverBit;
          end
        end
        ST_SEND: begin
          txPos_q <= txPos_q + POS_W'(1);
          if (txLast) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reqValid_q <= 1'b0;
      reqSop_q   <= 1'b0;
      reqEop_q   <= 1'b0;
      reqData_q  <= 8'h00;
    end else begin
      reqValid_q <= state_q == ST_SEND;
      reqSop_q   <= (state_q == ST_SEND) && (txPos_q == '0);
      reqEop_q   <= (state_q == ST_SEND) && txLast;
      reqData_q  <= (state_q == ST_SEND) ? txByte : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxPos_q       <= '0;
      rxGood_q      <= 1'b0;
      rxMatch_q     <= 1'b0;
      echoRspGot_q  <= 1'b0;
      echoRspOk_q   <= 1'b0;
      echoRspRing_q <= 1'b0;
    end else begin
      echoRspGot_q <= 1'b0;
      if (ring.rspValid) begin
        rxPos_q   <= rxPos + POS_W'(1);
        rxGood_q  <= rxGood;
        rxMatch_q <= rxMat;
        if (ring.rspEop) begin
          echoRspGot_q  <= rxGood;
          echoRspOk_q   <= rxGood && rxMat && (rxPos >= frameEnd - POS_W'(1));
          echoRspRing_q <= ring.rspRinglet;
        end
      end
    end
  end

  assign ring.reqValid = reqValid_q;
  assign ring.reqSop   = reqSop_q;
  assign ring.reqEop   = reqEop_q;
  assign ring.reqData  = reqData_q;
  assign busy          = state_q == ST_SEND;
  assign echoRspGot    = echoRspGot_q;
  assign echoRspOk     = echoRspOk_q;
  assign echoRspRing   = echoRspRing_q;

endmodule : rof_peer

// file: rof_ring_monitor.sv
// Checker for the request and echo reply streams between the two ends.
`timescale 1ns/1ps
module rof_ring_monitor
  import rof_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       reqValid,
  input wire logic       reqSop,
  input wire logic       reqEop,
  input wire logic [7:0] reqData,
  input wire logic       rspValid,
  input wire logic       rspSop,
  input wire logic       rspEop,
  input wire logic [7:0] rspData,
  input wire logic       rspRinglet
);
  // Byte indexes are wide enough for the longest frame the peer can send with LEN_W up to 8.
  logic [8:0] rspIdx_q;
  logic [8:0] reqIdx_q;
  wire  [8:0] rspIdx = rspSop ? 9'h000 : rspIdx_q;
  wire  [8:0] reqIdx = reqSop ? 9'h000 : reqIdx_q;

  always_ff @(posedge clk) begin
    if (reset) rspIdx_q <= 9'h000;
    else if (rspValid) rspIdx_q <= rspIdx + 9'h001;
  end

  always_ff @(posedge clk) begin
    if (reset) reqIdx_q <= 9'h000;
    else if (reqValid) reqIdx_q <= reqIdx + 9'h001;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  rsp_start_a: assert property (rspValid && rspSop |->
    $past(reqValid && reqSop, 6)) else $error("reply start without request");
  rsp_type_a: assert property (rspValid && rspSop |->
    rspData == OAM_CTRL_TYPE) else $error("reply type byte wrong");
  rsp_dest_a: assert property (rspValid && rspIdx == 9'h001 |->
    rspData == $past(reqData, 5)) else $error("reply destination wrong");
  rsp_code_a: assert property (rspValid && rspIdx == 9'h003 |->
    rspData == {GRP_FAULT, FN_ECHO_RSP}) else $error("reply code wrong");
  payload_copy_a: assert property (rspValid && rspIdx > 9'h003 |->
    rspData == $past(reqData, 6)) else $error("reply byte altered");
  rsp_end_a: assert property (rspValid && rspEop |->
    $past(reqValid && reqEop, 6)) else $error("reply length wrong");
  rsp_gapless_a: assert property (rspValid && !rspEop |=>
    rspValid) else $error("gap inside reply");
  ringlet_hold_a: assert property (rspValid && !rspSop |->
    $stable(rspRinglet)) else $error("reply ringlet moved mid frame");
  req_codes_a: assert property (reqValid && reqSop |-> ##3
    reqData[7:4] == GRP_FAULT && (reqData[3:0] == FN_ECHO_REQ ||
    reqData[3:0] == FN_FLUSH)) else $error("request codes wrong");
  req_minlen_a: assert property (reqValid && reqEop |->
    reqIdx >= 9'd23) else $error("request shorter than minimum");

  cover property (rspValid && rspEop);
  cover property (reqValid && reqSop ##3 reqData[3:0] == FN_FLUSH);
  cover property (rspValid && rspSop && rspRinglet);
endmodule : rof_ring_monitor

// file: ring_oam_frame_handler_bench.sv
// Testbench joining target and peer, plus a second target fed by the bench.
`timescale 1ns/1ps
module ring_oam_frame_handler_bench;
  import rof_pkg::*;
  logic       clk;
  logic       reset;
  logic [1:0] ringletFailed;
  logic       defaultRinglet;
  logic       startEcho;
  logic       startFlush;
  logic [7:0] dstAddr;
  logic [1:0] replyPath;
  logic       failoverBit;
  logic [7:0] payloadLen;
  logic [7:0] payloadSeed;
  logic       busy;
  logic       echoRspGot;
  logic       echoRspOk;
  logic       echoRspRing;
  wire  [5:0] evA;
  wire  [5:0] evB;
  int         cntA[6];
  int         cntB[6];
  int         num_errors;
  int         n_compared;
  int         cycles;

  rof_ring_if ringA();
  rof_ring_if ringB();
  assign evA[5] = ringA.rspValid & ringA.rspSop;
  assign evB[5] = ringB.rspValid & ringB.rspSop;

  rof_target rof_target_i (.clk(clk), .reset(reset), .myAddr(8'h21),
    .defaultRinglet(defaultRinglet), .ringletFailed(ringletFailed),
    .echoReqSeen(evA[0]), .echoRspSeen(evA[1]), .flushSeen(evA[2]),
    .dropEvent(evA[3]), .runtSeen(evA[4]), .ring(ringA.target));
  // A second target lets the bench send frames the peer never would.
  rof_target rof_target_i2 (.clk(clk), .reset(reset), .myAddr(8'h21),
    .defaultRinglet(defaultRinglet), .ringletFailed(ringletFailed),
    .echoReqSeen(evB[0]), .echoRspSeen(evB[1]), .flushSeen(evB[2]),
    .dropEvent(evB[3]), .runtSeen(evB[4]), .ring(ringB.target));
  rof_peer #(.LEN_W(8)) rof_peer_i (.clk(clk), .reset(reset),
    .myAddr(8'h42), .startEcho(startEcho), .startFlush(startFlush),
    .dstAddr(dstAddr), .replyPath(replyPath), .failoverBit(failoverBit),
    .payloadLen(payloadLen), .payloadSeed(payloadSeed), .busy(busy),
    .echoRspGot(echoRspGot), .echoRspOk(echoRspOk),
    .echoRspRing(echoRspRing), .ring(ringA.peer));
  rof_ring_monitor rof_ring_monitor_i (.clk(clk), .reset(reset),
    .reqValid(ringA.reqValid), .reqSop(ringA.reqSop),
    .reqEop(ringA.reqEop), .reqData(ringA.reqData),
    .rspValid(ringA.rspValid), .rspSop(ringA.rspSop),
    .rspEop(ringA.rspEop), .rspData(ringA.rspData),
    .rspRinglet(ringA.rspRinglet));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      cntA[i] += evA[i];
      cntB[i] += evB[i];
    end
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic echo(input logic [2:0] k);
    logic [1:0] fl;
    logic       base;
    logic       want;
    int         n;
    int         s;
    fl = k[1] ? 2'h2 : 2'h1;
    base = (k[1:0] == RPS_RING0) ? 1'b0 : (k[1:0] == RPS_RING1) ? 1'b1 : k[0];
    want = (k[2] == POLICY_PROTECTED && fl[base]) ? ~base : base;
    s = cntA[0];
    n = 0;
    @(posedge clk);
    replyPath <= k[1:0];
    failoverBit <= k[2];
    defaultRinglet <= k[0];
    ringletFailed <= fl;
    payloadLen <= 8'h05 * {5'h00, k};
    payloadSeed <= {k, 5'h0b};
    startEcho <= 1'b1;
    @(posedge clk);
    startEcho <= 1'b0;
    while (echoRspGot !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(echoRspGot, 1'b1);
    chk(echoRspOk, 1'b1);
    chk(echoRspRing, want);
    chk(ringA.rspRinglet, want);
    chk(cntA[0] - s, 1);
  endtask : echo

  task automatic quiet(input logic [7:0] da);
    int s[6];
    int n;
    s = cntA;
    n = 0;
    @(posedge clk);
    dstAddr <= da;
    payloadLen <= 8'h03;
    startFlush <= 1'b1;
    @(posedge clk);
    startFlush <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 100);
    repeat (10) @(posedge clk);
    #1;
    for (int i = 0; i < 6; i++) begin
      chk(cntA[i] - s[i], (i == 2 && da == 8'h21));
    end
  endtask : quiet

  task automatic frameB(input logic [7:0] ty, input logic [7:0] code,
                        input logic [7:0] ctl, input int len,
                        input logic [5:0] e);
    int         s[6];
    logic [7:0] b;
    s = cntB;
    for (int i = 0; i < len; i++) begin
      b = (i == 0) ? ty : (i == 1) ? 8'h21 : (i == 2) ? 8'h5a :
          (i == 3) ? code : (i == 4) ? ctl : 8'(i) ^ 8'ha5;
      @(posedge clk);
      ringB.reqValid <= 1'b1;
      ringB.reqSop <= (i == 0);
      ringB.reqEop <= (i == len - 1);
      ringB.reqData <= b;
    end
    @(posedge clk);
    ringB.reqValid <= 1'b0;
    ringB.reqSop <= 1'b0;
    ringB.reqEop <= 1'b0;
    ringB.reqData <= ~b;
    repeat (12) @(posedge clk);
    #1;
    for (int i = 0; i < 6; i++) begin
      chk(cntB[i] - s[i], e[i]);
    end
  endtask : frameB

  initial begin
    reset = 1'b1;
    ringletFailed = 2'h0;
    defaultRinglet = 1'b0;
    startEcho = 1'b0;
    startFlush = 1'b0;
    dstAddr = 8'h21;
    replyPath = 2'h0;
    failoverBit = 1'b0;
    payloadLen = 8'h00;
    payloadSeed = 8'h00;
    ringB.reqValid = 1'b0;
    ringB.reqSop = 1'b0;
    ringB.reqEop = 1'b0;
    ringB.reqData = 8'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      echo(3'(k));
    end
    quiet(8'h21);
    quiet(8'h33);
    frameB(8'h03, 8'h28, 8'h00, 24, 6'b001000);
    frameB(8'h03, 8'h12, 8'h00, 24, 6'b001000);
    frameB(8'h03, 8'h19, 8'h00, 24, 6'b000010);
    frameB(8'h03, 8'h11, 8'hff, 24, 6'b000100);
    frameB(8'h07, 8'h18, 8'h00, 24, 6'b000000);
    frameB(8'h03, 8'h18, 8'h06, 6, 6'b110001);
    chk(ringB.rspRinglet, 1'b1);
    finish_test();
  end
endmodule : ring_oam_frame_handler_bench
